// ### tpst_phy_model.sv
// Model of the attached link partners and backplane reference
`timescale 1ns/10ps
module tpst_phy_model (
  input  wire logic        sys_clk,
  input  wire logic        ref_on,
  input  wire logic [3:0]  phy_enable,
  input  wire logic [3:0]  phy_master,
  input  wire logic [3:0]  phy_speed_1g,
  input  wire logic [3:0]  peer_mst,
  output logic      [3:0]  link_up,
  output logic      [3:0]  rx_valid,
  output logic      [31:0] rx_data,
  output logic      [3:0]  rx_last,
  output logic             backplane_ref_clock
);
  // Link trains only with opposite roles; peers are fixed at 100 Mb/s
  assign link_up = phy_enable & (phy_master ^ peer_mst) & ~phy_speed_1g;
  // Reference held low when pulled from the backplane
  initial backplane_ref_clock = 1'b0;
  always #50 backplane_ref_clock = ref_on ? ~backplane_ref_clock : 1'b0;
  initial begin
    rx_valid = 4'h0;
    rx_last  = 4'h0;
    rx_data  = 32'h0000_0000;
  end
  // One byte a cycle; a released lane shows the inverse
  task automatic put(input int p, input logic [7:0] d, input logic last);
    @(posedge sys_clk);
    rx_valid[p]      <= 1'b1;
    rx_last[p]       <= last;
    rx_data[8*p +: 8] <= d;
    @(posedge sys_clk);
    rx_valid[p]      <= 1'b0;
    rx_last[p]       <= 1'b0;
    rx_data[8*p +: 8] <= ~d;
  endtask : put
endmodule : tpst_phy_model

// ### tpst_pkg.sv
// Constants, register map and field positions of the tap port block
package tpst_pkg;
  localparam int NPORT = 4;
  localparam int NTRIG = 8;
  localparam int NKEEP = 5;
  localparam int TW    = 64;
  localparam int DW    = 8;
  localparam int AW    = 8;
  // Timing in ns, with the cycle counts derived from it
  localparam int CLK_NS       = 50;
  localparam int REF_STEP_NS  = 100;
  localparam int REF_LOSS_NS  = 1000;
  localparam int RECONF_NS    = 10000;
  localparam int BLINK_NS     = 250000000;
  localparam int FADE_STEP_NS = 4000000;
  localparam int REF_LOSS_CYC = (REF_LOSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECONF_CYC   = (RECONF_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLINK_CYC    = BLINK_NS / CLK_NS;
  localparam int FADE_CYC     = FADE_STEP_NS / CLK_NS;
  localparam int BLK_W  = 23;
  localparam int FD_W   = 17;
  localparam int LOSS_W = 5;
  localparam int BSY_W  = 8;
  localparam int FADE_W = 9;
  // Register word addresses
  localparam logic [AW-1:0] A_PORT0 = 8'h00;
  localparam logic [AW-1:0] A_GSTAT = 8'h04;
  localparam logic [AW-1:0] A_TRIGF = 8'h05;
  localparam logic [AW-1:0] A_TLO   = 8'h08;
  localparam logic [AW-1:0] A_THI   = 8'h09;
  localparam logic [AW-1:0] A_TCMD  = 8'h0A;
  localparam logic [AW-1:0] A_KEEP  = 8'h10;
  localparam logic [AW-1:0] A_RXTS  = 8'h20;
  localparam logic [AW-1:0] A_TRIG  = 8'h40;
  localparam logic [AW-1:0] A_END   = 8'hC0;
  // Port word fields
  localparam int B_TAP  = 0;
  localparam int B_MST  = 1;
  localparam int B_1G   = 2;
  localparam int B_ID   = 3;
  localparam int B_MON  = 4;
  localparam int B_LINK = 8;
  localparam int B_SYNC = 9;
  localparam int B_BUSY = 10;
  localparam int B_REJ  = 11;
  // Global status and time command fields
  localparam int B_REFOK = 0;
  localparam int B_FATAL = 1;
  localparam int B_LOAD  = 4;
endpackage : tpst_pkg

// ### tpst_sva.sv
// Port checker of the tap port block
`timescale 1ns/10ps
module tpst_sva (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        fatal_err,
  input wire logic [3:0]  link_up,
  input wire logic [3:0]  rx_valid,
  input wire logic [31:0] rx_data,
  input wire logic [3:0]  tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic [3:0]  host_tx_valid,
  input wire logic [31:0] host_tx_data,
  input wire logic [3:0]  host_tx_ready,
  input wire logic [3:0]  mon_a_valid,
  input wire logic [31:0] mon_a_data,
  input wire logic [3:0]  phy_enable,
  input wire logic [3:0]  led_link_grn,
  input wire logic [3:0]  led_link_amb,
  input wire logic [3:0]  led_stat_red
);
  localparam int RED_WIN = 40;
  logic tap01_reg;
  // Pair 0/1 tap bit; either partner word sets it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tap01_reg <= 1'b0;
    end else if (reg_wr && reg_addr[7:1] == 7'h00) begin
      tap01_reg <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_tap_flip;
    reg_wr && reg_addr == 8'h00 && reg_wdata[0] != tap01_reg;
  endsequence
  sequence s_pair_live;
    tap01_reg && rx_valid[0] && link_up[1:0] == 2'b11 && phy_enable[1:0] == 2'b11;
  endsequence
  a_mode_drop: assert property (s_tap_flip |-> ##[1:2] phy_enable[1:0] == 2'b00)
    else $error("tap change kept the link");
  a_tap_fwd: assert property (s_pair_live |=> tx_valid[1] && tx_data[15:8] == $past(rx_data[7:0]))
    else $error("tap byte not forwarded");
  a_tap_refuse: assert property (tap01_reg |-> host_tx_ready[1:0] == 2'b00)
    else $error("host transmit open in tap");
  a_mon_pair: assert property (tap01_reg && mon_a_valid[1:0] == 2'b11 |-> mon_a_data[7:0] == mon_a_data[15:8])
    else $error("tap monitors differ");
  a_host_pass: assert property (host_tx_valid[2] && host_tx_ready[2] |=>
    tx_valid[2] && tx_data[23:16] == $past(host_tx_data[23:16]))
    else $error("host byte lost");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_link_off: assert property (!link_up[0] [*2] |-> !led_link_grn[0] && !led_link_amb[0])
    else $error("link light without link");
  a_led_excl: assert property ((led_link_grn & led_link_amb) == 4'h0)
    else $error("link light two colours");
  a_busy_ready: assert property (!phy_enable[0] |-> !host_tx_ready[0])
    else $error("ready while reconfiguring");
  a_fatal_red: assert property ($rose(fatal_err) |-> ##[1:RED_WIN] led_stat_red[0])
    else $error("no red on fatal");
endmodule : tpst_sva

bind tpst_top tpst_sva u_sva (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .fatal_err, .link_up, .rx_valid, .rx_data, .tx_valid, .tx_data, .host_tx_valid, .host_tx_data,
  .host_tx_ready, .mon_a_valid, .mon_a_data, .phy_enable, .led_link_grn, .led_link_amb, .led_stat_red);

// ### tpst_top.sv
// Four-port tap/direct control, indicators and time keepers
`timescale 1ns/10ps
module tpst_top #(
  parameter int unsigned BLINK_CYC = tpst_pkg::BLINK_CYC,
  parameter int unsigned FADE_CYC  = tpst_pkg::FADE_CYC,
  parameter bit          SPEED_SEL = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        backplane_ref_clock,
  input  wire logic [7:0]  trig_in,
  input  wire logic        fatal_err,
  input  wire logic [3:0]  link_up,
  input  wire logic [3:0]  rx_valid,
  input  wire logic [31:0] rx_data,
  input  wire logic [3:0]  rx_last,
  output logic      [3:0]  tx_valid,
  output logic      [31:0] tx_data,
  output logic      [3:0]  tx_last,
  input  wire logic [3:0]  host_tx_valid,
  input  wire logic [31:0] host_tx_data,
  input  wire logic [3:0]  host_tx_last,
  output logic      [3:0]  host_tx_ready,
  output logic      [3:0]  mon_a_valid,
  output logic      [31:0] mon_a_data,
  output logic      [3:0]  mon_a_last,
  output logic      [3:0]  mon_b_valid,
  output logic      [31:0] mon_b_data,
  output logic      [3:0]  mon_b_last,
  input  wire logic [3:0]  gm_time_load,
  input  wire logic [63:0] gm_time,
  output logic      [3:0]  phy_enable,
  output logic      [3:0]  phy_master,
  output logic      [3:0]  phy_speed_1g,
  output logic      [3:0]  led_link_grn,
  output logic      [3:0]  led_link_amb,
  output logic      [3:0]  led_stat_grn,
  output logic      [3:0]  led_stat_amb,
  output logic      [3:0]  led_stat_red
);
  localparam int NP = tpst_pkg::NPORT;
  localparam int TW = tpst_pkg::TW;

  typedef struct packed {
    logic [3:0]                    tap;
    logic [3:0]                    mst;
    logic [3:0]                    g1;
    logic [3:0]                    pid;
    logic [3:0]                    mon;
    logic [3:0]                    cfgd;
    logic [3:0]                    rej;
    logic [3:0]                    syncd;
    logic [3:0][tpst_pkg::BSY_W-1:0] busy;
    logic [TW-1:0]                 lt;
    logic [3:0][TW-1:0]            nt;
    logic [3:0][TW-1:0]            rx_lt;
    logic [3:0][TW-1:0]            rx_nt;
    logic [7:0][4:0][TW-1:0]       trig_ts;
    logic [7:0]                    trig_prev;
    logic [7:0]                    trig_flag;
    logic [TW-1:0]                 stage;
    logic [31:0]                   shadow;
    logic [31:0]                   rdata;
    logic                          ref_s1;
    logic                          ref_s2;
    logic                          ref_prev;
    logic                          ref_ok;
    logic [tpst_pkg::LOSS_W-1:0]   loss;
    logic                          fatal;
    logic [3:0]                    infr;
    logic [3:0]                    act;
    logic [tpst_pkg::BLK_W-1:0]    blk_cnt;
    logic                          blk;
    logic [tpst_pkg::FD_W-1:0]     fd_cnt;
    logic [tpst_pkg::FADE_W-1:0]   fade;
    logic [7:0]                    pwm;
    logic [3:0]                    tx_v;
    logic [3:0]                    tx_l;
    logic [3:0][7:0]               tx_d;
    logic [3:0]                    ma_v;
    logic [3:0]                    ma_l;
    logic [3:0][7:0]               ma_d;
    logic [3:0]                    mb_v;
    logic [3:0]                    mb_l;
    logic [3:0][7:0]               mb_d;
    logic [3:0]                    ll_g;
    logic [3:0]                    ll_a;
    logic [3:0]                    ls_g;
    logic [3:0]                    ls_a;
    logic [3:0]                    ls_r;
  } tpst_state_s;

  tpst_state_s r_reg;
  tpst_state_s r_next;
  logic [3:0][7:0] rxd;
  logic [3:0][7:0] htd;
  logic [3:0]      live;
  logic [4:0][TW-1:0] kt;

  // Unpack byte lanes and per-port liveness
  assign rxd = rx_data;
  assign htd = host_tx_data;
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      live[p] = (r_reg.busy[p] == '0) && link_up[p];
    end
    kt = {r_reg.nt, r_reg.lt};
  end

  // Host transmit refused in tap mode or while link is down
  assign host_tx_ready = ~r_reg.tap & live;

  // Static role and speed straight from settled configuration
  assign phy_master   = r_reg.mst;
  assign phy_speed_1g = r_reg.g1;
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      phy_enable[p] = r_reg.busy[p] == '0;
    end
  end

  assign reg_rdata    = r_reg.rdata;
  assign tx_valid     = r_reg.tx_v;
  assign tx_data      = r_reg.tx_d;
  assign tx_last      = r_reg.tx_l;
  assign mon_a_valid  = r_reg.ma_v;
  assign mon_a_data   = r_reg.ma_d;
  assign mon_a_last   = r_reg.ma_l;
  assign mon_b_valid  = r_reg.mb_v;
  assign mon_b_data   = r_reg.mb_d;
  assign mon_b_last   = r_reg.mb_l;
  assign led_link_grn = r_reg.ll_g;
  assign led_link_amb = r_reg.ll_a;
  assign led_stat_grn = r_reg.ls_g;
  assign led_stat_amb = r_reg.ls_a;
  assign led_stat_red = r_reg.ls_r;

  // Next-state logic for the whole block
  always_comb begin
    logic          edge_ref;
    logic [TW-1:0] lstep;
    logic [7:0]    lvl;
    logic [1:0]    fon;
    logic [7:0]    a;
    logic [7:0]    ta;
    logic [2:0]    k;
    int            q;
    int            e;
    edge_ref = 1'b0;
    lstep    = '0;
    lvl      = '0;
    fon      = '0;
    a        = reg_addr;
    ta       = '0;
    k        = '0;
    q        = 0;
    e        = 0;
    r_next   = r_reg;

    // Reference clock: two-flop sync, edge detect on second stage
    r_next.ref_s1   = backplane_ref_clock;
    r_next.ref_s2   = r_reg.ref_s1;
    r_next.ref_prev = r_reg.ref_s2;
    edge_ref = r_reg.ref_s2 & ~r_reg.ref_prev;
    if (edge_ref) begin
      r_next.loss   = '0;
      r_next.ref_ok = 1'b1;
    end else if (r_reg.loss == tpst_pkg::LOSS_W'(tpst_pkg::REF_LOSS_CYC)) begin
      r_next.ref_ok = 1'b0;
    end else begin
      r_next.loss = r_reg.loss + 1'b1;
    end

    // Local time advances per reference period, else per own clock
    if (r_reg.ref_ok) begin
      lstep = edge_ref ? TW'(tpst_pkg::REF_STEP_NS) : '0;
    end else begin
      lstep = TW'(tpst_pkg::CLK_NS);
    end
    r_next.lt = r_reg.lt + lstep;

    // Network keepers: master follows local, slave free-runs
    for (int p = 0; p < NP; p++) begin
      if (r_reg.mst[p]) begin
        r_next.nt[p] = r_reg.nt[p] + lstep;
      end else begin
        r_next.nt[p] = r_reg.nt[p] + TW'(tpst_pkg::CLK_NS);
      end
    end

    // Reconfiguration hold-off counts down to zero
    for (int p = 0; p < NP; p++) begin
      if (r_reg.busy[p] != '0) begin
        r_next.busy[p] = r_reg.busy[p] - 1'b1;
      end
    end

    // Register writes
    if (reg_wr) begin
      if (a < tpst_pkg::A_GSTAT) begin
        q = int'(a[1:0]) ^ 1;
        r_next.cfgd[a[1:0]] = 1'b1;
        r_next.pid[a[1:0]]  = reg_wdata[tpst_pkg::B_ID];
        r_next.mon[a[1:0]]  = reg_wdata[tpst_pkg::B_MON];
        if (reg_wdata[tpst_pkg::B_TAP] != r_reg.tap[a[1:0]]) begin
          r_next.busy[a[1:0]] = tpst_pkg::BSY_W'(tpst_pkg::RECONF_CYC);
          r_next.busy[q]      = tpst_pkg::BSY_W'(tpst_pkg::RECONF_CYC);
        end
        // Pair-wide tap; the other pair is untouched
        r_next.tap[a[1:0]] = reg_wdata[tpst_pkg::B_TAP];
        r_next.tap[q]      = reg_wdata[tpst_pkg::B_TAP];
        if (reg_wdata[tpst_pkg::B_MST] != r_reg.mst[a[1:0]]) begin
          r_next.busy[a[1:0]]  = tpst_pkg::BSY_W'(tpst_pkg::RECONF_CYC);
          r_next.syncd[a[1:0]] = 1'b0;
        end
        r_next.mst[a[1:0]] = reg_wdata[tpst_pkg::B_MST];
        if ((SPEED_SEL ? reg_wdata[tpst_pkg::B_1G] : 1'b1) != r_reg.g1[a[1:0]]) begin
          r_next.busy[a[1:0]] = tpst_pkg::BSY_W'(tpst_pkg::RECONF_CYC);
        end
        r_next.g1[a[1:0]] = SPEED_SEL ? reg_wdata[tpst_pkg::B_1G] : 1'b1;
        if (reg_wdata[tpst_pkg::B_REJ]) begin
          r_next.rej[a[1:0]] = 1'b0;
        end
      end else if (a == tpst_pkg::A_TRIGF) begin
        r_next.trig_flag = r_reg.trig_flag & ~reg_wdata[7:0];
      end else if (a == tpst_pkg::A_TLO) begin
        r_next.stage[31:0] = reg_wdata;
      end else if (a == tpst_pkg::A_THI) begin
        r_next.stage[63:32] = reg_wdata;
      end else if (a == tpst_pkg::A_TCMD) begin
        k = reg_wdata[2:0];
        // Load sets a keeper, otherwise the stage is a signed offset
        if (k == 3'h0) begin
          r_next.lt = reg_wdata[tpst_pkg::B_LOAD] ? r_reg.stage : r_next.lt + r_reg.stage;
        end else if (k <= 3'(NP)) begin
          if (reg_wdata[tpst_pkg::B_LOAD]) begin
            r_next.nt[k - 3'h1] = r_reg.stage;
          end else begin
            r_next.nt[k - 3'h1] = r_next.nt[k - 3'h1] + r_reg.stage;
          end
        end
      end
    end

    // Grandmaster time lands on slave ports only
    for (int p = 0; p < NP; p++) begin
      if (gm_time_load[p] && !r_reg.mst[p]) begin
        r_next.nt[p]    = gm_time;
        r_next.syncd[p] = 1'b1;
      end
    end

    // Host sends refused in tap mode are remembered; set beats clear
    for (int p = 0; p < NP; p++) begin
      if (host_tx_valid[p] && r_reg.tap[p]) begin
        r_next.rej[p] = 1'b1;
      end
    end

    // Catastrophic error sticks until reset
    if (fatal_err) begin
      r_next.fatal = 1'b1;
    end

    // Trigger capture by every keeper in one cycle
    r_next.trig_prev = trig_in;
    for (int t = 0; t < tpst_pkg::NTRIG; t++) begin
      if (trig_in[t] && !r_reg.trig_prev[t]) begin
        r_next.trig_ts[t] = kt;
        r_next.trig_flag[t] = 1'b1;
      end
    end

    // Data paths and frame stamps
    for (int p = 0; p < NP; p++) begin
      q = p ^ 1;
      e = p & 2;
      if (r_reg.tap[p]) begin
        // Partner forwarding, like a cable between the two links
        r_next.tx_v[p] = rx_valid[q] & live[q] & live[p];
        r_next.tx_d[p] = rxd[q];
        r_next.tx_l[p] = rx_last[q];
        r_next.ma_v[p] = rx_valid[e] & live[e] & r_reg.mon[p];
        r_next.ma_d[p] = rxd[e];
        r_next.ma_l[p] = rx_last[e];
        r_next.mb_v[p] = rx_valid[e + 1] & live[e + 1] & r_reg.mon[p];
        r_next.mb_d[p] = rxd[e + 1];
        r_next.mb_l[p] = rx_last[e + 1];
      end else begin
        r_next.tx_v[p] = host_tx_valid[p] & host_tx_ready[p];
        r_next.tx_d[p] = htd[p];
        r_next.tx_l[p] = host_tx_last[p];
        r_next.ma_v[p] = rx_valid[p] & live[p] & r_reg.mon[p];
        r_next.ma_d[p] = rxd[p];
        r_next.ma_l[p] = rx_last[p];
        r_next.mb_v[p] = host_tx_valid[p] & host_tx_ready[p] & r_reg.mon[p];
        r_next.mb_d[p] = htd[p];
        r_next.mb_l[p] = host_tx_last[p];
      end
      // Stamp on the first byte of each received frame
      if (rx_valid[p] && live[p]) begin
        if (!r_reg.infr[p]) begin
          r_next.rx_lt[p] = r_reg.lt;
          r_next.rx_nt[p] = r_reg.nt[p];
        end
        r_next.infr[p] = !rx_last[p];
      end
    end

    // Blink and fade timebases
    if (r_reg.blk_cnt == tpst_pkg::BLK_W'(BLINK_CYC - 1)) begin
      r_next.blk_cnt = '0;
      r_next.blk     = ~r_reg.blk;
      r_next.act     = '0;
    end else begin
      r_next.blk_cnt = r_reg.blk_cnt + 1'b1;
    end
    if (r_reg.fd_cnt == tpst_pkg::FD_W'(FADE_CYC - 1)) begin
      r_next.fd_cnt = '0;
      r_next.fade   = r_reg.fade + 1'b1;
    end else begin
      r_next.fd_cnt = r_reg.fd_cnt + 1'b1;
    end
    r_next.pwm = r_reg.pwm + 1'b1;
    lvl = r_reg.fade[8] ? ~r_reg.fade[7:0] : r_reg.fade[7:0];
    // Second pair uses the mirrored ramp
    fon[0] = r_reg.pwm < lvl;
    fon[1] = r_reg.pwm < ~lvl;

    // Activity is held until the next blink half period
    for (int p = 0; p < NP; p++) begin
      if ((rx_valid[p] && live[p]) || r_next.tx_v[p]) begin
        r_next.act[p] = 1'b1;
      end
    end

    // Indicator colours
    for (int p = 0; p < NP; p++) begin
      r_next.ll_g[p] = 1'b0;
      r_next.ll_a[p] = 1'b0;
      if (live[p]) begin
        r_next.ll_g[p] = !r_reg.g1[p] && (!r_reg.act[p] || r_reg.blk);
        r_next.ll_a[p] = r_reg.g1[p] && (!r_reg.act[p] || r_reg.blk);
      end
      r_next.ls_g[p] = 1'b0;
      r_next.ls_a[p] = 1'b0;
      r_next.ls_r[p] = 1'b0;
      if (r_reg.fatal) begin
        r_next.ls_r[p] = r_reg.blk;
      end else if (!r_reg.cfgd[p]) begin
        r_next.ls_g[p] = 1'b0;
      end else if (r_reg.pid[p]) begin
        r_next.ls_g[p] = r_reg.blk;
      end else if (!r_reg.mst[p] && !r_reg.syncd[p]) begin
        r_next.ls_a[p] = r_reg.blk;
      end else begin
        r_next.ls_g[p] = r_reg.mst[p] && (!r_reg.tap[p] || fon[p >> 1]);
        r_next.ls_a[p] = !r_reg.mst[p] && (!r_reg.tap[p] || fon[p >> 1]);
      end
    end

    // Read data stands only in the cycle after the strobe
    r_next.rdata = '0;
    if (reg_rd) begin
      if (a < tpst_pkg::A_GSTAT) begin
        r_next.rdata[tpst_pkg::B_TAP]  = r_reg.tap[a[1:0]];
        r_next.rdata[tpst_pkg::B_MST]  = r_reg.mst[a[1:0]];
        r_next.rdata[tpst_pkg::B_1G]   = r_reg.g1[a[1:0]];
        r_next.rdata[tpst_pkg::B_ID]   = r_reg.pid[a[1:0]];
        r_next.rdata[tpst_pkg::B_MON]  = r_reg.mon[a[1:0]];
        r_next.rdata[tpst_pkg::B_LINK] = link_up[a[1:0]];
        r_next.rdata[tpst_pkg::B_SYNC] = r_reg.syncd[a[1:0]];
        r_next.rdata[tpst_pkg::B_BUSY] = r_reg.busy[a[1:0]] != '0;
        r_next.rdata[tpst_pkg::B_REJ]  = r_reg.rej[a[1:0]];
      end else if (a == tpst_pkg::A_GSTAT) begin
        r_next.rdata[tpst_pkg::B_REFOK] = r_reg.ref_ok;
        r_next.rdata[tpst_pkg::B_FATAL] = r_reg.fatal;
      end else if (a == tpst_pkg::A_TRIGF) begin
        r_next.rdata[7:0] = r_reg.trig_flag;
      end else if (a == tpst_pkg::A_TLO) begin
        r_next.rdata = r_reg.stage[31:0];
      end else if (a == tpst_pkg::A_THI) begin
        r_next.rdata = r_reg.stage[63:32];
      end else if (a >= tpst_pkg::A_KEEP && a < tpst_pkg::A_KEEP + 8'h0A) begin
        // Low word read freezes the high word for a coherent pair
        if (!a[0]) begin
          r_next.rdata  = kt[a[3:1]][31:0];
          r_next.shadow = kt[a[3:1]][63:32];
        end else begin
          r_next.rdata = r_reg.shadow;
        end
      end else if (a >= tpst_pkg::A_RXTS && a < tpst_pkg::A_RXTS + 8'h10) begin
        if (a[1]) begin
          r_next.rdata = a[0] ? r_reg.rx_nt[a[3:2]][63:32] : r_reg.rx_nt[a[3:2]][31:0];
        end else begin
          r_next.rdata = a[0] ? r_reg.rx_lt[a[3:2]][63:32] : r_reg.rx_lt[a[3:2]][31:0];
        end
      end else if (a >= tpst_pkg::A_TRIG && a < tpst_pkg::A_END) begin
        ta = a - tpst_pkg::A_TRIG;
        if (ta[3:1] < 3'(tpst_pkg::NKEEP)) begin
          r_next.rdata = ta[0] ? r_reg.trig_ts[ta[6:4]][ta[3:1]][63:32]
                               : r_reg.trig_ts[ta[6:4]][ta[3:1]][31:0];
        end
      end
    end
  end

  // Single state register; slow speed default on the selectable part
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg    <= '0;
      r_reg.g1 <= SPEED_SEL ? 4'h0 : 4'hF;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule : tpst_top

// ### tpst_top_bench.sv
// Directed bench of the tap port block
`timescale 1ns/10ps
module tpst_top_bench;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ref_on = 1'b1;
  logic        fatal_err = 1'b0;
  logic        backplane_ref_clock;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  trig_in = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] host_tx_data = 32'h0000_0000;
  logic [63:0] gm_time = 64'h0000_0000_0000_0000;
  logic [3:0]  host_tx_valid = 4'h0;
  logic [3:0]  host_tx_last = 4'h0;
  logic [3:0]  gm_time_load = 4'h0;
  logic [31:0] reg_rdata, rx_data, tx_data, mon_a_data, mon_b_data;
  logic [3:0]  link_up, rx_valid, rx_last, tx_valid, tx_last, host_tx_ready, phy_enable;
  logic [3:0]  mon_a_valid, mon_a_last, mon_b_valid, mon_b_last, phy_master, phy_speed_1g;
  logic [3:0]  led_link_grn, led_link_amb, led_stat_grn, led_stat_amb, led_stat_red;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // Short blink and fade keep LED checks brief
  tpst_top #(.BLINK_CYC(8), .FADE_CYC(2)) DUT (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .backplane_ref_clock, .trig_in, .fatal_err, .link_up, .rx_valid, .rx_data,
    .rx_last, .tx_valid, .tx_data, .tx_last, .host_tx_valid, .host_tx_data, .host_tx_last,
    .host_tx_ready, .mon_a_valid, .mon_a_data, .mon_a_last, .mon_b_valid, .mon_b_data, .mon_b_last,
    .gm_time_load, .gm_time, .phy_enable, .phy_master, .phy_speed_1g, .led_link_grn, .led_link_amb,
    .led_stat_grn, .led_stat_amb, .led_stat_red);
  // Peers: ports 0/1 slave, ports 2/3 master
  tpst_phy_model u_phy (.sys_clk, .ref_on, .phy_enable, .phy_master, .phy_speed_1g,
    .peer_mst(4'b1100), .link_up, .rx_valid, .rx_data, .rx_last, .backplane_ref_clock);
  always #25 sys_clk = ~sys_clk;
  // Hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk
  // Host byte for one cycle; released lane inverted
  task automatic hput(input int p, input logic [7:0] d);
    @(posedge sys_clk);
    host_tx_valid[p]       <= 1'b1;
    host_tx_last[p]        <= 1'b1;
    host_tx_data[8*p +: 8] <= d;
    @(posedge sys_clk);
    host_tx_valid[p]       <= 1'b0;
    host_tx_last[p]        <= 1'b0;
    host_tx_data[8*p +: 8] <= ~d;
    @(negedge sys_clk);
  endtask : hput
  task automatic fwd(input int pi, input logic [7:0] d);
    u_phy.put(pi, d, 1'b1);
    @(negedge sys_clk);
    chk(tx_valid[pi ^ 1], 1'b1);
    chk(tx_data[8*(pi ^ 1) +: 8], d);
    chk(pi ? {mon_b_valid, mon_b_last, mon_b_data[15:0]}
           : {mon_a_valid, mon_a_last, mon_a_data[15:0]}, {8'h33, d, d});
  endtask : fwd
  initial begin
    logic [31:0] d;
    logic [31:0] e;
    logic        seen;
    repeat (8) @(posedge sys_clk);
    chk({phy_enable, led_link_grn, led_link_amb, led_stat_grn, led_stat_amb, led_stat_red}, 24'hF0_0000);
    nrst <= 1'b1;
    rchk(8'h02, 32'h0000_0100);
    rchk(tpst_pkg::A_END, 32'h0000_0000);
    // Ports 0/1 turn master; both busy meanwhile, link comes up after
    wr(tpst_pkg::A_PORT0, 32'h0000_0002);
    wr(8'h01, 32'h0000_0002);
    rchk(tpst_pkg::A_PORT0, 32'h0000_0402);
    repeat (tpst_pkg::RECONF_CYC) @(posedge sys_clk);
    rchk(tpst_pkg::A_PORT0, 32'h0000_0102);
    chk({led_stat_grn[0], led_link_grn[0], led_link_amb[0]}, 3'b110);
    $display("roles done");
    // Tap on port 0 pulls port 1 along; ports 2/3 stay direct
    wr(8'h01, 32'h0000_0012);
    wr(tpst_pkg::A_PORT0, 32'h0000_0013);
    repeat (tpst_pkg::RECONF_CYC) @(posedge sys_clk);
    rchk(8'h01, 32'h0000_0113);
    chk(host_tx_ready, 4'b1100);
    // Keepers 0..4 get distinct high words
    for (int k = 0; k < 5; k++) begin
      wr(tpst_pkg::A_TLO, 32'h0000_0000);
      wr(tpst_pkg::A_THI, 32'(k + 1));
      wr(tpst_pkg::A_TCMD, 32'(16 + k));
      rd(8'(tpst_pkg::A_KEEP + 2 * k), d);
      rchk(8'(tpst_pkg::A_KEEP + 2 * k + 1), 32'(k + 1));
    end
    wr(tpst_pkg::A_TLO, 32'h0000_0001);
    wr(tpst_pkg::A_THI, 32'h0000_0000);
    wr(tpst_pkg::A_TCMD, 32'h0000_0000);
    rd(tpst_pkg::A_KEEP, d);
    chk(d % 100, 1);
    $display("time done");
    for (int i = 0; i < 4; i++) begin
      fwd(i % 2, 8'(8'hA0 + i));
    end
    for (int p = 0; p < 2; p++) begin
      rchk(8'(tpst_pkg::A_RXTS + 4 * p + 1), 32'h0000_0001);
      rchk(8'(tpst_pkg::A_RXTS + 4 * p + 3), 32'(p + 2));
    end
    hput(0, 8'h3C);
    rchk(tpst_pkg::A_PORT0, 32'h0000_0913);
    hput(2, 8'h5A);
    chk({tx_valid[2], tx_last[2], tx_data[23:16]}, 10'h35A);
    $display("tap done");
    @(posedge sys_clk);
    trig_in <= 8'h08;
    repeat (4) @(posedge sys_clk);
    rchk(tpst_pkg::A_TRIGF, 32'h0000_0008);
    for (int k = 0; k < 5; k++) begin
      rchk(8'(tpst_pkg::A_TRIG + 48 + 2 * k + 1), 32'(k + 1));
    end
    wr(tpst_pkg::A_TRIGF, 32'h0000_0008);
    rchk(tpst_pkg::A_TRIGF, 32'h0000_0000);
    @(posedge sys_clk);
    gm_time      <= 64'h0000_0009_0000_0000;
    gm_time_load <= 4'b0100;
    @(posedge sys_clk);
    gm_time_load <= 4'h0;
    rd(8'h16, d);
    rchk(8'h17, 32'h0000_0009);
    rchk(8'h02, 32'h0000_0300);
    $display("sync done");
    // Reference pulled: fallback counts 50 ns a cycle
    ref_on <= 1'b0;
    repeat (30) @(posedge sys_clk);
    rchk(tpst_pkg::A_GSTAT, 32'h0000_0000);
    rd(tpst_pkg::A_KEEP, d);
    repeat (8) @(posedge sys_clk);
    rd(tpst_pkg::A_KEEP, e);
    chk(e - d, 500);
    ref_on <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rchk(tpst_pkg::A_GSTAT, 32'h0000_0001);
    @(posedge sys_clk);
    fatal_err <= 1'b1;
    @(posedge sys_clk);
    fatal_err <= 1'b0;
    seen = 1'b0;
    repeat (20) begin
      @(negedge sys_clk);
      seen = seen | led_stat_red[0];
    end
    chk(seen, 1'b1);
    rchk(tpst_pkg::A_GSTAT, 32'h0000_0003);
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rchk(tpst_pkg::A_GSTAT, 32'h0000_0001);
    $display("fault done");
    end_sim();
  end
endmodule : tpst_top_bench
